// [design/mbx_pkg.sv]
// package: constants and types shared by the auto-restart mailbox controller
`default_nettype none
package mbx_pkg;
	localparam int unsigned ARG_W      = 32;                 // width of one scalar argument
	localparam int unsigned N_IN       = 4;                  // input scalar arguments
	localparam int unsigned N_OUT      = 2;                  // output scalar arguments
	localparam int unsigned IDX_W      = 2;                  // argument index width
	localparam int unsigned CNT_W      = 32;                 // iteration counter width
	localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;   // count reset value
	localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;   // count step
	localparam logic [ARG_W-1:0] ARG_RST  = 32'h0000_0000;   // argument reset value
	typedef logic [ARG_W-1:0] arg_t;
	typedef enum logic {CHAIN_HS, BASIC_HS} hs_mode_t;
	typedef enum {ST_IDLE, ST_RUN, ST_DONE_HOLD} ctrl_state_t;
endpackage : mbx_pkg
`default_nettype wire

// [design/mbx_bank_if.sv]
// interface: write and read paths of one mailbox register bank
`timescale 1ns/1ps
`default_nettype none
interface mbx_bank_if #(parameter int unsigned N = 4);
	logic                       host_we;     // host writes one host-side word
	logic [mbx_pkg::IDX_W-1:0]  host_idx;    // host word index
	mbx_pkg::arg_t              host_wdata;  // host write data
	logic                       kern_we;     // kernel writes one kernel-side word
	logic [mbx_pkg::IDX_W-1:0]  kern_idx;    // kernel word index
	mbx_pkg::arg_t              kern_wdata;  // kernel write data
	logic                       h2k;         // copy host side into kernel side
	logic                       k2h;         // copy kernel side into host side
	mbx_pkg::arg_t              host_q [N];  // host-side copy
	mbx_pkg::arg_t              kern_q [N];  // kernel-side copy
	modport ctrl (output host_we, host_idx, host_wdata, kern_we, kern_idx, kern_wdata, h2k, k2h,
		input host_q, kern_q);
	modport bank (input host_we, host_idx, host_wdata, kern_we, kern_idx, kern_wdata, h2k, k2h,
		output host_q, kern_q);
endinterface : mbx_bank_if
`default_nettype wire

// [design/mbx_bank.sv]
// module: double-buffered register pair (host-side and kernel-side copies)
`timescale 1ns/1ps
`default_nettype none
module mbx_bank #(
	parameter int unsigned N = 4
) (
	// clock and reset
	input  wire logic   ref_clk_i,
	input  wire logic   nrst_i,
	// access port
	mbx_bank_if.bank    bus
);
	import mbx_pkg::*;
	arg_t host_r [N];
	arg_t host_nxt [N];
	arg_t kern_r [N];
	arg_t kern_nxt [N];

	// next values: a whole-bank copy wins over a single-word write on the same side
	always_comb begin
		host_nxt = host_r;
		kern_nxt = kern_r;
		// an index past the bank size writes nothing instead of reaching outside the array
		for (int i = 0; i < N; i++) begin
			if (bus.host_we && bus.host_idx == IDX_W'(i)) begin
				host_nxt[i] = bus.host_wdata;
			end
			if (bus.kern_we && bus.kern_idx == IDX_W'(i)) begin
				kern_nxt[i] = bus.kern_wdata;
			end
		end
		if (bus.h2k) begin
			kern_nxt = host_r;
		end
		if (bus.k2h) begin
			host_nxt = kern_r;
		end
	end

	// storage registers
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < N; i++) begin
				host_r[i] <= ARG_RST;
				kern_r[i] <= ARG_RST;
			end
		end else begin
			host_r <= host_nxt;
			kern_r <= kern_nxt;
		end
	end

	assign bus.host_q = host_r;
	assign bus.kern_q = kern_r;
endmodule : mbx_bank
`default_nettype wire

// [design/auto_restart_mailbox_ctrl.sv]
// module: control of a self-restarting kernel with input and output mailboxes
//
// Behaviour
// - counted mode: one host start, kernel restarts itself until count reached
// - never-ending mode: restart forever until reset or host stop
// - chained handshake preferred; basic handshake also selectable
// - host soft reset stops the self-restarting kernel
// - host argument writes touch only the host-side input copy
// - after write request, whole input copy moves to kernel at next restart
// - after read request, output kernel copy goes to host copy on completion
// - device flags host when input transfer has happened
// - device flags fresh output copy, which then stays stable
// - kernel rereads its input copy freely between host updates
// - kernel writes output copy freely; only requested transfer updates host copy
// - input and output mailboxes use independent register pairs
// - mailbox buffering covers every scalar argument
// - chained: continue low while done high halts, holds done and return value
`timescale 1ns/1ps
`default_nettype none
module auto_restart_mailbox_ctrl (
	// clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        nrst_i,
	// host control
	input  wire logic                        host_start_i,
	input  wire logic                        host_stop_i,
	input  wire logic                        soft_reset_i,
	input  wire logic                        auto_restart_en_i,
	input  wire logic [mbx_pkg::CNT_W-1:0]   iter_count_i,
	input  wire mbx_pkg::hs_mode_t           hs_mode_i,
	// host mailbox access
	input  wire logic                        host_in_we_i,
	input  wire logic [mbx_pkg::IDX_W-1:0]   host_in_idx_i,
	input  wire mbx_pkg::arg_t               host_in_wdata_i,
	input  wire logic                        mbx_write_req_i,
	input  wire logic                        mbx_read_req_i,
	input  wire logic [mbx_pkg::IDX_W-1:0]   host_out_idx_i,
	output logic [mbx_pkg::ARG_W-1:0]        host_out_rdata_o,
	output logic                             in_xfer_done_o,
	output logic                             out_fresh_o,
	output logic                             write_pending_o,
	output logic                             read_pending_o,
	// kernel core side
	output logic                             kern_start_o,
	input  wire logic                        kern_finish_i,
	input  wire mbx_pkg::arg_t               kern_return_i,
	input  wire logic [mbx_pkg::IDX_W-1:0]   kern_in_idx_i,
	output logic [mbx_pkg::ARG_W-1:0]        kern_in_rdata_o,
	input  wire logic                        kern_out_we_i,
	input  wire logic [mbx_pkg::IDX_W-1:0]   kern_out_idx_i,
	input  wire mbx_pkg::arg_t               kern_out_wdata_i,
	// block handshake ports
	input  wire logic                        downstream_continue_i,
	output logic                             exec_done_o,
	output logic                             idle_o,
	output logic [mbx_pkg::ARG_W-1:0]        return_value_port_o,
	output logic [mbx_pkg::CNT_W-1:0]        runs_done_o
);
	import mbx_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ctrl_state_t      state_r, state_nxt;
	logic             start_r, start_nxt;
	logic             done_r, done_nxt;
	logic             idle_r, idle_nxt;
	arg_t             ret_r, ret_nxt;
	logic [CNT_W-1:0] runs_r, runs_nxt;
	logic             stop_r, stop_nxt;
	logic             wreq_r, wreq_nxt;
	logic             rreq_r, rreq_nxt;
	logic             in_ok_r, in_ok_nxt;
	logic             out_ok_r, out_ok_nxt;
	arg_t             out_rd_r, out_rd_nxt;
	arg_t             in_rd_r, in_rd_nxt;
	logic             restart;
	logic             finish_evt;

	mbx_bank_if #(.N(N_IN))  in_if ();
	mbx_bank_if #(.N(N_OUT)) out_if ();

	// separate banks so input and output share no storage
	mbx_bank #(.N(N_IN)) u_in_bank (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.bus       (in_if)
	);
	mbx_bank #(.N(N_OUT)) u_out_bank (
		.ref_clk_i (ref_clk_i),
		.nrst_i    (nrst_i),
		.bus       (out_if)
	);

	// true when another run is due: counted or endless, and not stopped
	function automatic logic more_runs(input logic en, input logic stop,
		input logic [CNT_W-1:0] runs, input logic [CNT_W-1:0] limit);
		if (!en || stop) begin
			more_runs = 1'b0;
		end else if (limit == CNT_ZERO) begin
			more_runs = 1'b1;
		end else begin
			more_runs = (runs < limit);
		end
	endfunction : more_runs

	// ----------------------------------------------------------------
	// mailbox wiring
	// ----------------------------------------------------------------
	// host writes reach only the host-side input copy; every scalar is buffered
	assign in_if.host_we    = host_in_we_i;
	assign in_if.host_idx   = host_in_idx_i;
	assign in_if.host_wdata = host_in_wdata_i;
	assign in_if.kern_we    = 1'b0;
	assign in_if.kern_idx   = '0;
	assign in_if.kern_wdata = ARG_RST;
	assign in_if.h2k        = restart && wreq_r;
	assign in_if.k2h        = 1'b0;
	// kernel writes reach only the kernel-side output copy
	assign out_if.host_we    = 1'b0;
	assign out_if.host_idx   = '0;
	assign out_if.host_wdata = ARG_RST;
	assign out_if.kern_we    = kern_out_we_i;
	assign out_if.kern_idx   = kern_out_idx_i;
	assign out_if.kern_wdata = kern_out_wdata_i;
	assign out_if.h2k        = 1'b0;
	assign out_if.k2h        = finish_evt && rreq_r;

	// a run completes once, when the core reports finish in the run state
	assign finish_evt = (state_r == ST_RUN) && kern_finish_i;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	// restart is the moment the next run is launched; start from idle counts too
	always_comb begin
		state_nxt = state_r;
		start_nxt = 1'b0;
		done_nxt  = 1'b0;
		idle_nxt  = idle_r;
		ret_nxt   = ret_r;
		runs_nxt  = runs_r;
		stop_nxt  = stop_r || host_stop_i;
		restart   = 1'b0;
		case (state_r)
			ST_IDLE: begin
				idle_nxt = 1'b1;
				if (host_start_i) begin
					restart   = 1'b1;
					start_nxt = 1'b1;
					idle_nxt  = 1'b0;
					runs_nxt  = CNT_ZERO;
					stop_nxt  = 1'b0;
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (kern_finish_i) begin
					done_nxt  = 1'b1;
					ret_nxt   = kern_return_i;      // valid with done
					runs_nxt  = runs_r + CNT_ONE;
					state_nxt = ST_DONE_HOLD;
				end
			end
			default: begin
				// chained mode holds done and return while continue is low
				if (hs_mode_i == CHAIN_HS && !downstream_continue_i) begin
					done_nxt = 1'b1;
				end else if (more_runs(auto_restart_en_i, stop_r, runs_r, iter_count_i)) begin
					restart   = 1'b1;
					start_nxt = 1'b1;
					state_nxt = ST_RUN;
				end else begin
					idle_nxt  = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	// mailbox request flags: a new request in the transfer cycle is kept
	always_comb begin
		wreq_nxt   = wreq_r;
		rreq_nxt   = rreq_r;
		in_ok_nxt  = in_ok_r;
		out_ok_nxt = out_ok_r;
		if (in_if.h2k) begin
			wreq_nxt  = 1'b0;
			in_ok_nxt = 1'b1;
		end
		if (mbx_write_req_i) begin
			wreq_nxt  = 1'b1;
			in_ok_nxt = 1'b0;
		end
		if (out_if.k2h) begin
			rreq_nxt   = 1'b0;
			out_ok_nxt = 1'b1;
		end
		if (mbx_read_req_i) begin
			rreq_nxt = 1'b1;
			if (!out_if.k2h) begin
				out_ok_nxt = 1'b0;
			end
		end
		// the output bank is smaller than the index range; unused indexes read as reset value
		out_rd_nxt = ARG_RST;
		for (int i = 0; i < N_OUT; i++) begin
			if (host_out_idx_i == IDX_W'(i)) begin
				out_rd_nxt = out_if.host_q[i];      // stable host copy
			end
		end
		in_rd_nxt  = in_if.kern_q[kern_in_idx_i];   // reread freely
	end

	// ----------------------------------------------------------------
	// registers; the soft reset clears control like a power-on reset
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r  <= ST_IDLE;
			start_r  <= 1'b0;
			done_r   <= 1'b0;
			idle_r   <= 1'b1;
			ret_r    <= ARG_RST;
			runs_r   <= CNT_ZERO;
			stop_r   <= 1'b0;
			wreq_r   <= 1'b0;
			rreq_r   <= 1'b0;
			in_ok_r  <= 1'b0;
			out_ok_r <= 1'b0;
			out_rd_r <= ARG_RST;
			in_rd_r  <= ARG_RST;
		end else if (soft_reset_i) begin
			state_r  <= ST_IDLE;
			start_r  <= 1'b0;
			done_r   <= 1'b0;
			idle_r   <= 1'b1;
			ret_r    <= ARG_RST;
			runs_r   <= CNT_ZERO;
			stop_r   <= 1'b0;
			wreq_r   <= 1'b0;
			rreq_r   <= 1'b0;
			in_ok_r  <= 1'b0;
			out_ok_r <= 1'b0;
			out_rd_r <= out_rd_nxt;
			in_rd_r  <= in_rd_nxt;
		end else begin
			state_r  <= state_nxt;
			start_r  <= start_nxt;
			done_r   <= done_nxt;
			idle_r   <= idle_nxt;
			ret_r    <= ret_nxt;
			runs_r   <= runs_nxt;
			stop_r   <= stop_nxt;
			wreq_r   <= wreq_nxt;
			rreq_r   <= rreq_nxt;
			in_ok_r  <= in_ok_nxt;
			out_ok_r <= out_ok_nxt;
			out_rd_r <= out_rd_nxt;
			in_rd_r  <= in_rd_nxt;
		end
	end

	// outputs straight from flip-flops
	assign kern_start_o        = start_r;
	assign exec_done_o         = done_r;
	assign idle_o              = idle_r;
	assign return_value_port_o = ret_r;
	assign runs_done_o         = runs_r;
	assign in_xfer_done_o      = in_ok_r;
	assign out_fresh_o         = out_ok_r;
	assign write_pending_o     = wreq_r;
	assign read_pending_o      = rreq_r;
	assign host_out_rdata_o    = out_rd_r;
	assign kern_in_rdata_o     = in_rd_r;
endmodule : auto_restart_mailbox_ctrl
`default_nettype wire

// [tb/auto_restart_mailbox_ctrl_assertions.sv]
// checker: port-level properties of the auto-restart mailbox controller
`timescale 1ns/1ps
`default_nettype none
module auto_restart_mailbox_ctrl_assertions (
	// clock, resets and host side
	input wire logic                      ref_clk_i,
	input wire logic                      nrst_i,
	input wire logic                      soft_reset_i,
	input wire logic                      host_start_i,
	input wire logic [mbx_pkg::CNT_W-1:0] iter_count_i,
	input wire mbx_pkg::hs_mode_t         hs_mode_i,
	input wire logic                      mbx_write_req_i,
	input wire logic                      mbx_read_req_i,
	input wire logic                      write_pending_o,
	input wire logic                      in_xfer_done_o,
	input wire logic                      read_pending_o,
	input wire logic                      out_fresh_o,
	// kernel and block handshake
	input wire logic                      kern_start_o,
	input wire logic                      kern_finish_i,
	input wire mbx_pkg::arg_t             kern_return_i,
	input wire logic                      downstream_continue_i,
	input wire logic                      exec_done_o,
	input wire logic                      idle_o,
	input wire logic [mbx_pkg::ARG_W-1:0] return_value_port_o,
	input wire logic [mbx_pkg::CNT_W-1:0] runs_done_o
);
	import mbx_pkg::*;
	// ----
	// properties
	// ----
	// soft reset restarts the control state, so no property is judged across it
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i || soft_reset_i);
	logic go_on;
	// done may release: continue high, or basic handshake ignores it
	assign go_on = downstream_continue_i || hs_mode_i == BASIC_HS;
	a_start_taken: assert property (host_start_i && idle_o |=> kern_start_o && !idle_o)
		else $error("start not launched");
	a_done_follows: assert property (kern_finish_i && !idle_o && !exec_done_o
		|=> exec_done_o && return_value_port_o == $past(kern_return_i))
		else $error("done or return value missing after finish");
	a_done_held: assert property (exec_done_o && hs_mode_i == CHAIN_HS && !downstream_continue_i
		|=> exec_done_o && $stable(return_value_port_o)) else $error("done not held");
	a_done_single: assert property (exec_done_o && go_on |=> !exec_done_o)
		else $error("done longer than one cycle");
	a_count_stop: assert property (exec_done_o && go_on && iter_count_i != CNT_ZERO
		&& runs_done_o >= iter_count_i |=> idle_o && !kern_start_o) else $error("restart past count");
	a_in_xfer: assert property (kern_start_o && $past(write_pending_o) && !$past(mbx_write_req_i)
		|-> in_xfer_done_o && !write_pending_o) else $error("input transfer not flagged");
	a_out_fresh: assert property (kern_finish_i && !idle_o && !exec_done_o && read_pending_o
		|=> out_fresh_o && read_pending_o == $past(mbx_read_req_i)) else $error("output not fresh");
	a_busy_no_idle: assert property (kern_start_o |-> !idle_o ##1 !kern_start_o)
		else $error("start pulse malformed");
endmodule : auto_restart_mailbox_ctrl_assertions
bind auto_restart_mailbox_ctrl auto_restart_mailbox_ctrl_assertions u_chk (.*);
`default_nettype wire

// [tb/auto_restart_mailbox_ctrl_test.sv]
// testbench: self-checking runs of the auto-restart mailbox controller
`timescale 1ns/1ps
`default_nettype none
module auto_restart_mailbox_ctrl_test;
	import mbx_pkg::*;
	// ----
	// ports and expectations
	// ----
	logic             ref_clk_i = 1'h0, nrst_i = 1'h0, host_start_i = 1'h0, host_stop_i = 1'h0;
	logic             soft_reset_i = 1'h0, auto_restart_en_i = 1'h0, host_in_we_i = 1'h0;
	logic             mbx_write_req_i = 1'h0, mbx_read_req_i = 1'h0, kern_finish_i = 1'h0;
	logic             kern_out_we_i = 1'h0, downstream_continue_i = 1'h1;
	logic [CNT_W-1:0] iter_count_i = CNT_ZERO;
	hs_mode_t         hs_mode_i = CHAIN_HS;
	logic [IDX_W-1:0] host_in_idx_i = '0, host_out_idx_i = '0, kern_in_idx_i = '0, kern_out_idx_i = '0;
	arg_t             host_in_wdata_i = ARG_RST, kern_return_i = ARG_RST, kern_out_wdata_i = ARG_RST;
	logic [ARG_W-1:0] host_out_rdata_o, kern_in_rdata_o, return_value_port_o;
	logic [CNT_W-1:0] runs_done_o;
	logic             in_xfer_done_o, out_fresh_o, write_pending_o, read_pending_o, kern_start_o, exec_done_o;
	logic             idle_o;
	arg_t             hin[N_IN], kin_e[N_IN], kout[N_OUT], hout_e[N_OUT];
	int               error_cnt = 0, num_checks = 0;
	int               nr_tab[4] = '{3, 4, 2, 1};
	auto_restart_mailbox_ctrl u_auto_restart_mailbox_ctrl (.*);
	// 125 MHz clock
	always #4 ref_clk_i = ~ref_clk_i;
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	// restart expected: auto mode, not stopped, count not yet reached
	function automatic logic due(input int runs, input logic stop);
		return auto_restart_en_i && !stop && (iter_count_i == CNT_ZERO || runs < iter_count_i);
	endfunction : due
	// one-cycle pulse: 0 start, 1 stop, 2 write request, 3 read request, 4 soft reset
	task automatic req(input int k);
		@(posedge ref_clk_i);
		{soft_reset_i, mbx_read_req_i, mbx_write_req_i, host_stop_i, host_start_i} <= 5'h1 << k;
		@(posedge ref_clk_i);
		{soft_reset_i, mbx_read_req_i, mbx_write_req_i, host_stop_i, host_start_i} <= 5'h0;
	endtask : req
	// one word into the host-side input copy or the kernel-side output copy
	task automatic wr(input logic kern, input int i, input arg_t d);
		@(posedge ref_clk_i);
		{kern_out_we_i, host_in_we_i} <= kern ? 2'h2 : 2'h1;
		kern_out_idx_i <= IDX_W'(i);
		host_in_idx_i <= IDX_W'(i);
		kern_out_wdata_i <= d;
		host_in_wdata_i <= d;
		if (kern) kout[i] = d;
		else hin[i] = d;
		@(posedge ref_clk_i);
		{kern_out_we_i, host_in_we_i} <= 2'h0;
	endtask : wr
	// reads are registered, so data shows one edge after the index
	task automatic rd(input int i);
		@(posedge ref_clk_i);
		kern_in_idx_i <= IDX_W'(i);
		host_out_idx_i <= IDX_W'(i % N_OUT);
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk("kern_in_rdata", kin_e[i], kern_in_rdata_o);
		chk("host_out_rdata", hout_e[i % N_OUT], host_out_rdata_o);
	endtask : rd
	// finish a run; continue drops for n-1 extra done cycles
	task automatic fin(input logic cont, input int n);
		arg_t ret;
		ret = $urandom;
		@(posedge ref_clk_i);
		kern_finish_i <= 1'h1;
		kern_return_i <= ret;
		downstream_continue_i <= cont;
		@(posedge ref_clk_i);
		kern_finish_i <= 1'h0;
		kern_return_i <= ~ret;
		for (int k = 0; k < n; k++) begin
			@(negedge ref_clk_i);
			chk("exec_done", 1'h1, exec_done_o);
			chk("return_value", ret, return_value_port_o);
			@(posedge ref_clk_i);
			if (k >= n - 2) downstream_continue_i <= 1'h1;
		end
	endtask : fin
	// ----
	// scenarios: counted, never-ending with hold and stop, basic with soft reset, single
	// ----
	initial begin
		void'($urandom(32'hC763));
		hout_e = '{default: ARG_RST};
		repeat (3) @(posedge ref_clk_i);
		nrst_i <= 1'h1;
		for (int s = 0; s < 4; s++) begin
			@(posedge ref_clk_i);
			auto_restart_en_i <= (s != 3);
			iter_count_i <= (s == 0) ? 32'h3 : CNT_ZERO;
			hs_mode_i <= (s == 2) ? BASIC_HS : CHAIN_HS;
			if (s == 0) begin
				for (int i = N_IN - 1; i >= 0; i--) wr(1'h0, i, $urandom);
				req(2);
				kin_e = hin;
			end
			req(0);
			@(negedge ref_clk_i);
			chk("kern_start", 1'h1, kern_start_o);
			for (int r = 1; r <= nr_tab[s]; r++) begin
				if (s == 0) begin
					if (r == 2) kin_e = hin;
					chk("in_xfer_done", 1'h1, in_xfer_done_o);
					chk("write_pending", 1'h0, write_pending_o);
				end
				for (int i = 0; i < N_IN; i++) rd(i);
				if (s == 0 && r == 1) begin
					wr(1'h0, 0, ~hin[0]);
					rd(0);
					req(2);
					@(negedge ref_clk_i);
					chk("in_xfer_done", 1'h0, in_xfer_done_o);
					chk("write_pending", 1'h1, write_pending_o);
				end
				if (s == 0 && r == 2) begin
					req(3);
					@(negedge ref_clk_i);
					chk("read_pending", 1'h1, read_pending_o);
				end
				for (int i = 0; i < N_OUT; i++) wr(1'h1, i, $urandom);
				if (s == 1 && r == 4) req(1);
				if (s == 2 && r == 2) begin
					req(4);
					@(negedge ref_clk_i);
					chk("idle", 1'h1, idle_o);
					chk("runs_done", CNT_ZERO, runs_done_o);
					chk("out_fresh", 1'h0, out_fresh_o);
					chk("in_xfer_done", 1'h0, in_xfer_done_o);
				end else begin
					fin(!((s == 1 && r == 2) || (s == 2 && r == 1)), (s == 1 && r == 2) ? 3 : 1);
					if (s == 0 && r == 2) hout_e = kout;
					@(negedge ref_clk_i);
					chk("out_fresh", (s == 0) ? r >= 2 : s < 3, out_fresh_o);
					chk("read_pending", 1'h0, read_pending_o);
					chk("runs_done", r, runs_done_o);
					chk("kern_start", due(r, s == 1 && r == 4), kern_start_o);
					chk("idle", !due(r, s == 1 && r == 4), idle_o);
				end
			end
		end
		for (int i = 0; i < N_IN; i++) rd(i);
		end_sim();
	end
endmodule : auto_restart_mailbox_ctrl_test
`default_nettype wire
